// file: rtl/enc_out.sv
/*
 * Encoder output generator: turns quarter-cycle shaft steps into two
 * quadrature channels and an index, each driven as a complementary pair.
 * Assumes step pulses come from an asynchronous position sensor, at most
 * one quarter cycle per step, and no faster than the receiver can follow.
 */
`timescale 1ns/100ps
`include "enc_out_regs.svh"

module enc_out
    import enc_out_pkg::*;
#(
    parameter cpr_t CPR = `CPR_DEFAULT
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic NRST,
    // Shaft steps, one per quarter cycle, asynchronous
    input  wire logic STEP_CW,
    input  wire logic STEP_CCW,
    // Quadrature pair one
    output logic      QA_P,
    output logic      QA_N,
    // Quadrature pair two
    output logic      QB_P,
    output logic      QB_N,
    // Index pair
    output logic      IDX_P,
    output logic      IDX_N
);
    localparam logic [17:0] STEPS_REV = 18'(CPR) * 18'd4;
    localparam logic [17:0] LAST_POS  = STEPS_REV - 18'd1;
    localparam logic [17:0] IDX_POS   = `INDEX_POS;

    quad_state_t st_q;
    quad_state_t st_d;
    logic [17:0] pos_q;
    logic [17:0] pos_d;
    logic        cw_rise;
    logic        ccw_rise;
    logic        fwd;
    logic        rev;
    logic        qa_w;
    logic        qb_w;
    logic        idx_w;
    logic        at_last;
    logic        at_first;
    logic [17:0] pos_up;
    logic [17:0] pos_dn;

    enc_step_sync u_sync_cw (
        .CLK    (CLK),
        .NRST   (NRST),
        .pin_in (STEP_CW),
        .rise   (cw_rise)
    );

    enc_step_sync u_sync_ccw (
        .CLK    (CLK),
        .NRST   (NRST),
        .pin_in (STEP_CCW),
        .rise   (ccw_rise)
    );

    // Simultaneous opposite steps cancel
    assign fwd = cw_rise & ~ccw_rise;
    assign rev = ccw_rise & ~cw_rise;

    // Gray sequence 00,10,11,01 forward; reverse walks it backward
    function automatic quad_state_t step_fn(input quad_state_t s, input logic up);
        unique case (s)
            PH_00: step_fn = up ? PH_10 : PH_01;
            PH_10: step_fn = up ? PH_11 : PH_00;
            PH_11: step_fn = up ? PH_01 : PH_10;
            PH_01: step_fn = up ? PH_00 : PH_11;
        endcase
    endfunction

    assign st_d = (fwd | rev) ? step_fn(st_q, fwd) : st_q;

    // Position wraps after CPR cycles of four steps, either way round
    assign at_last  = (pos_q == LAST_POS);
    assign at_first = (pos_q == 18'd0);
    assign pos_up   = at_last ? 18'd0 : pos_q + 18'd1;
    assign pos_dn   = at_first ? LAST_POS : pos_q - 18'd1;
    assign pos_d    = fwd ? pos_up : rev ? pos_dn : pos_q;

    assign qa_w  = (st_d == PH_10) | (st_d == PH_11);
    assign qb_w  = (st_d == PH_11) | (st_d == PH_01);
    // Index decoded from the next position alone, high when it equals IDX_POS
    assign idx_w = (pos_d == IDX_POS);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= PH_00;
            pos_q <= 18'd0;
        end else begin
            st_q <= st_d;
            pos_q <= pos_d;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            QA_P <= 1'b0;
            QA_N <= 1'b1;
            QB_P <= 1'b0;
            QB_N <= 1'b1;
            IDX_P <= 1'b0;
            IDX_N <= 1'b1;
        end else begin
            QA_P <= qa_w;
            QA_N <= ~qa_w;
            QB_P <= qb_w;
            QB_N <= ~qb_w;
            IDX_P <= idx_w;
            IDX_N <= ~idx_w;
        end
    end

    a_pair_compl: assert property (@(posedge CLK) disable iff (!NRST)
        (QA_P != QA_N) && (QB_P != QB_N) && (IDX_P != IDX_N))
        else $error("output pair not complementary");

    a_one_edge_step: assert property (@(posedge CLK) disable iff (!NRST)
        !((QA_P != $past(QA_P)) && (QB_P != $past(QB_P))))
        else $error("both channels toggled together");

    a_cw_lead: assert property (@(posedge CLK) disable iff (!NRST)
        (fwd && !QA_P && !QB_P) |=> (QA_P && !QB_P))
        else $error("clockwise step did not raise channel one first");

    a_ccw_lead: assert property (@(posedge CLK) disable iff (!NRST)
        (rev && !QA_P && !QB_P) |=> (!QA_P && QB_P))
        else $error("counter-clockwise step did not raise channel two first");

    a_idle_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (!fwd && !rev) |=> $stable(QA_P) && $stable(QB_P))
        else $error("channel changed without a step");

    a_index_quad: assert property (@(posedge CLK) disable iff (!NRST)
        IDX_P |-> (QA_P && QB_P))
        else $error("index high outside its quarter cycle");

    a_index_pos: assert property (@(posedge CLK) disable iff (!NRST)
        IDX_P == (pos_q == 18'd2))
        else $error("index not tied to shaft position");

    a_rev_wrap: assert property (@(posedge CLK) disable iff (!NRST)
        (fwd && pos_q == STEPS_REV - 18'd1) |=> (pos_q == 18'd0) && !QA_P && !QB_P)
        else $error("revolution wrap not at CPR cycles");

    a_pos_range: assert property (@(posedge CLK) disable iff (!NRST)
        pos_q < STEPS_REV)
        else $error("position beyond one revolution");

    a_state_pos: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == quad_state_t'(pos_q[1:0]))
        else $error("channel state out of step with position");

    // Exactly one channel moves per step, and which one depends on direction
    a_fwd_one: assert property (@(posedge CLK) disable iff (!NRST)
        fwd |=> ((QA_P != $past(QA_P)) != (QB_P != $past(QB_P))))
        else $error("forward step did not move exactly one channel");

    a_rev_one: assert property (@(posedge CLK) disable iff (!NRST)
        rev |=> ((QA_P != $past(QA_P)) != (QB_P != $past(QB_P))))
        else $error("reverse step did not move exactly one channel");

    a_cw_order: assert property (@(posedge CLK) disable iff (!NRST)
        fwd |=> ((QA_P != $past(QA_P)) == ($past(QA_P) == $past(QB_P))))
        else $error("clockwise step moved the wrong channel");

    a_ccw_order: assert property (@(posedge CLK) disable iff (!NRST)
        rev |=> ((QB_P != $past(QB_P)) == ($past(QA_P) == $past(QB_P))))
        else $error("counter-clockwise step moved the wrong channel");

    // Each channel is high on two of the four positions, a quarter apart
    a_duty_a: assert property (@(posedge CLK) disable iff (!NRST)
        QA_P == (pos_q[1] ^ pos_q[0]))
        else $error("channel one high outside its half cycle");

    a_duty_b: assert property (@(posedge CLK) disable iff (!NRST)
        QB_P == pos_q[1])
        else $error("channel two not a quarter behind channel one");

    // Position bookkeeping across steps and wraps
    a_ccw_wrap: assert property (@(posedge CLK) disable iff (!NRST)
        (rev && at_first) |=> (pos_q == LAST_POS) && !QA_P && QB_P)
        else $error("reverse wrap not to the last position");

    a_pos_up: assert property (@(posedge CLK) disable iff (!NRST)
        (fwd && !at_last) |=> (pos_q == $past(pos_q) + 18'd1))
        else $error("forward step did not advance position by one");

    a_pos_down: assert property (@(posedge CLK) disable iff (!NRST)
        (rev && !at_first) |=> (pos_q == $past(pos_q) - 18'd1))
        else $error("reverse step did not retreat position by one");

    a_cancel_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (cw_rise && ccw_rise) |=> $stable(pos_q) && $stable(IDX_P))
        else $error("opposite steps together moved the shaft");

    // Index lasts one step and is entered from either side
    a_index_once: assert property (@(posedge CLK) disable iff (!NRST)
        ((fwd || rev) && IDX_P) |=> !IDX_P)
        else $error("index held over more than one step");

    a_index_enter: assert property (@(posedge CLK) disable iff (!NRST)
        (fwd && pos_q == 18'd1) |=> IDX_P)
        else $error("index missed on forward entry");

    a_ccw_enter: assert property (@(posedge CLK) disable iff (!NRST)
        (rev && pos_q == 18'd3) |=> IDX_P)
        else $error("index missed on reverse entry");

endmodule

// file: rtl/enc_out_regs.svh
/*
 * Constants for the incremental encoder output generator.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ENC_OUT_REGS_SVH
`define ENC_OUT_REGS_SVH

`define CPR_MIN          16'd2500
`define CPR_MAX          16'd7500
`define CPR_DEFAULT      16'd2500
`define STATES_PER_CYCLE 3'd4
`define SYNC_STAGES      2
`define FREQ_MAX_KHZ     750
`define CLK_MHZ          100
// Shaft position whose quarter cycle carries the index
`define INDEX_POS        18'd2
// Shortest step spacing: a cycle at 750 kHz is four steps
`define MIN_STEP_CYCLES  ((`CLK_MHZ * 1000) / (`FREQ_MAX_KHZ * 4))

`endif

// file: rtl/enc_out_pkg.sv
/*
 * Types for the incremental encoder output generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package enc_out_pkg;

    typedef enum logic [1:0] {
        PH_00 = 2'b00,
        PH_10 = 2'b01,
        PH_11 = 2'b10,
        PH_01 = 2'b11
    } quad_state_t;

    typedef logic [15:0] cpr_t;

endpackage

// file: rtl/enc_step_sync.sv
/*
 * Two-stage synchroniser and rising-edge detector for the shaft step inputs.
 * Assumes the step pins are asynchronous to CLK.
 */
`timescale 1ns/100ps
module enc_step_sync (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic NRST,
    // Raw input and synchronised rising-edge pulse
    input  wire logic pin_in,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    assign rise = sync_q & ~last_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
endmodule

// file: test/quad_rx_model.sv
/* Receiver model: differential line receiver and 4x quadrature counter.
   Assumes the encoder pairs and the bench clock. */
`timescale 1ns/100ps
module quad_rx_model (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Differential pairs
    input  wire logic        A_P,
    input  wire logic        A_N,
    input  wire logic        B_P,
    input  wire logic        B_N,
    // Decoded count and double-toggle flag
    output logic      [15:0] pos,
    output logic             bad
);
    logic [1:0] s1_q, s2_q, s3_q;
    wire  [1:0] ab  = {A_P & ~A_N, B_P & ~B_N};
    wire        fwd = (s2_q == {~s3_q[0], s3_q[1]});
    wire        rev = (s3_q == {~s2_q[0], s2_q[1]});
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            {s1_q, s2_q, s3_q, pos, bad} <= '0;
        end else begin
            {s3_q, s2_q, s1_q} <= {s2_q, s1_q, ab};
            pos <= fwd ? pos + 16'h1 : rev ? pos - 16'h1 : pos;
            bad <= bad | (s2_q == ~s3_q);
        end
    end
endmodule

// file: test/testbench.sv
/* Self-checking bench for the encoder output generator.
   Assumes CPR of 4, so one revolution is 16 steps. */
`timescale 1ns/100ps
module testbench;
    logic        CLK = 1'b0;
    logic        NRST, STEP_CW, STEP_CCW;
    logic        QA_P, QA_N, QB_P, QB_N, IDX_P, IDX_N, bad;
    logic [15:0] pos;
    int          fail_count, cmp_count, p, hits;
    enc_out #(.CPR(16'h4)) u_enc_out (.CLK(CLK), .NRST(NRST), .STEP_CW(STEP_CW),
        .STEP_CCW(STEP_CCW), .QA_P(QA_P), .QA_N(QA_N), .QB_P(QB_P), .QB_N(QB_N),
        .IDX_P(IDX_P), .IDX_N(IDX_N));
    quad_rx_model u_quad_rx_model (.CLK(CLK), .NRST(NRST), .A_P(QA_P), .A_N(QA_N),
        .B_P(QB_P), .B_N(QB_N), .pos(pos), .bad(bad));
    initial begin
        CLK = 0;
        forever #5 CLK = ~CLK;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Expected pins from shaft position: walk 00,10,11,01; index at 2
    task look;
        logic a, b, i;
        a = (p % 4 == 1) || (p % 4 == 2);
        b = (p % 4 >= 2);
        i = (p == 2);
        chk(16'({QA_P, QA_N, QB_P, QB_N, IDX_P, IDX_N}), 16'({a, ~a, b, ~b, i, ~i}));
    endtask
    task step(input logic cw, input logic ccw);
        STEP_CW  <= cw;
        STEP_CCW <= ccw;
        repeat (4) @(negedge CLK);
        STEP_CW  <= 1'b0;
        STEP_CCW <= 1'b0;
        repeat (30) @(negedge CLK);
        if (cw && !ccw) p = (p + 1) % 16;
        if (ccw && !cw) p = (p + 15) % 16;
        if (IDX_P === 1'b1) hits++;
        look();
    endtask
    task t_cw;
        hits = 0;
        repeat (16) step(1'b1, 1'b0);
        chk(16'(hits), 16'h1);
        chk(pos, 16'h10);
        step(1'b1, 1'b0);
    endtask
    task t_ccw;
        repeat (6) step(1'b0, 1'b1);
        chk(pos, 16'hb);
        chk(16'(bad), 16'h0);
    endtask
    task t_cancel;
        step(1'b1, 1'b1);
        chk(pos, 16'hb);
    endtask
    task t_reset;
        NRST = 1'b0;
        repeat (6) @(negedge CLK);
        NRST = 1'b1;
        p = 0;
        look();
    endtask
    initial begin
        {STEP_CW, STEP_CCW, fail_count, cmp_count} = '0;
        t_reset();
        t_cw();
        t_ccw();
        t_cancel();
        step(1'b1, 1'b0);
        t_reset();
        step(1'b1, 1'b0);
        chk(pos, 16'h1);
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge CLK);
        fail_count++;
        stop_test();
    end
endmodule
